// file: rtl/mm_clock_crossing_adapter.sv
// memory-mapped crossing between an upstream master port and a slower downstream slave port
// assumes the slave side samples its port only on cycles where slv_en pulses
// Operation
// - handshake mode crosses requests by req/ack toggles
// - handshake starts next transfer only after delivery
// - fifo mode queues commands and responses
// - fifo mode allows several outstanding transactions
// - auto picks fifo for burst links
// - handshake adapter holds master until completion
// - in fifo mode the bridge buffers commands and data in queues
// - each accepted transfer is reissued downstream
// - downstream port idle without upstream access
// - return data and valid are registered
// - stall present in first request cycle in handshake mode; fifo mode stalls only when the command queue fills
// - first-cycle flag only in first cycle
// - stall output registered, never combinational from request
// - control toggles pass two-stage synchronizers
// - master stalled on capture, released after ack
`timescale 1ns/100ps
module mm_clock_crossing_adapter
    import crossing_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // configuration
    input wire xing_mode_t xing_mode,
    input wire logic link_bursts,
    // upstream master port
    input wire logic m_read,
    input wire logic m_write,
    input wire logic [ADDR_W-1:0] m_addr,
    input wire logic [DATA_W-1:0] m_wdata,
    output logic m_wait,
    output logic [DATA_W-1:0] m_rdata,
    output logic m_rvalid,
    // downstream slave port
    output logic slv_en,
    output logic s_read,
    output logic s_write,
    output logic [ADDR_W-1:0] s_addr,
    output logic [DATA_W-1:0] s_wdata,
    output logic s_first,
    input wire logic s_stall,
    input wire logic [DATA_W-1:0] s_rdata,
    input wire logic s_rvalid
);
    typedef enum logic [1:0] {M_IDLE, M_WAIT_ACK, M_RELEASE} mst_state_t;
    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_RDWAIT} slv_state_t;

    logic fifo_on, m_req;
    // master-side state
    mst_state_t mst_state_reg, mst_state_next;
    logic req_tgl_reg, req_tgl_next;
    logic [CMD_W-1:0] hs_cmd_reg, hs_cmd_next;
    logic wait_reg, wait_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic [SYNC_LEN-1:0] ack_sync_reg, ack_sync_next;
    logic ack_seen_reg, ack_seen_next;
    // slave-side state
    slv_state_t slv_state_reg, slv_state_next;
    logic [CMD_W-1:0] cmd_reg, cmd_next;
    logic first_reg, first_next;
    logic ack_tgl_reg, ack_tgl_next;
    logic [DATA_W-1:0] hs_rdata_reg, hs_rdata_next;
    logic [SYNC_LEN-1:0] req_sync_reg, req_sync_next;
    logic req_seen_reg, req_seen_next;
    logic [DIV_W-1:0] div_reg, div_next;
    // queues
    logic cmd_push, cmd_pop, cmd_full, cmd_empty;
    logic [CMD_W-1:0] cmd_head;
    logic [CNT_W-1:0] cmd_count, cmd_count_after;
    logic rsp_push, rsp_pop, rsp_full, rsp_empty;
    logic [DATA_W-1:0] rsp_head;

    assign fifo_on = is_fifo_mode(xing_mode, link_bursts);
    assign m_req = m_read || m_write;

    // slower downstream rate as a one-cycle enable
    always_comb begin
        div_next = (div_reg == SLV_DIV_LAST) ? '0 : DIV_W'(div_reg + 1'b1);
    end
    assign slv_en = (div_reg == SLV_DIV_LAST);

    // command and response queues
    crossing_fifo #(.W(CMD_W), .DEPTH(CMD_DEPTH), .CW(CNT_W)) cmd_q (
        .clk(ref_clk),
        .rst(rst),
        .push(cmd_push),
        .wdata({m_write, m_addr, m_wdata}),
        .pop(cmd_pop),
        .rdata(cmd_head),
        .count(cmd_count),
        .full(cmd_full),
        .empty(cmd_empty)
    );

    crossing_fifo #(.W(DATA_W), .DEPTH(RSP_DEPTH), .CW(CNT_W)) rsp_q (
        .clk(ref_clk),
        .rst(rst),
        .push(rsp_push),
        .wdata(s_rdata),
        .pop(rsp_pop),
        .rdata(rsp_head),
        .count(),
        .full(rsp_full),
        .empty(rsp_empty)
    );

    // master side
    always_comb begin
        mst_state_next = mst_state_reg;
        req_tgl_next = req_tgl_reg;
        hs_cmd_next = hs_cmd_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        ack_seen_next = ack_seen_reg;
        ack_sync_next = {ack_sync_reg[SYNC_LEN-2:0], ack_tgl_reg};
        cmd_push = fifo_on && m_req && !wait_reg;
        rsp_pop = fifo_on && !rsp_empty;
        cmd_count_after = CNT_W'(cmd_count + CNT_W'(cmd_push) - CNT_W'(cmd_pop));
        wait_next = WAIT_RST;
        if (fifo_on) begin
            wait_next = (cmd_count_after == CNT_W'(CMD_DEPTH));
            if (rsp_pop) begin
                rdata_next = rsp_head;
                rvalid_next = 1'b1;
            end
        end
        unique case (mst_state_reg)
            M_IDLE: begin
                if (!fifo_on && m_req) begin
                    hs_cmd_next = {m_write, m_addr, m_wdata};
                    req_tgl_next = !req_tgl_reg;
                    mst_state_next = M_WAIT_ACK;
                end
            end
            M_WAIT_ACK: begin
                wait_next = 1'b1;
                if (toggled(ack_sync_reg[SYNC_LEN-1], ack_seen_reg)) begin
                    ack_seen_next = !ack_seen_reg;
                    wait_next = 1'b0;
                    if (!hs_cmd_reg[CMD_W-1]) begin
                        rdata_next = hs_rdata_reg;
                        rvalid_next = 1'b1;
                    end
                    mst_state_next = M_RELEASE;
                end
            end
            M_RELEASE: begin
                wait_next = 1'b1;
                mst_state_next = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mst_state_reg <= M_IDLE;
            req_tgl_reg <= 1'b0;
            hs_cmd_reg <= '0;
            wait_reg <= WAIT_RST;
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
            ack_sync_reg <= '0;
            ack_seen_reg <= 1'b0;
            div_reg <= '0;
        end else begin
            mst_state_reg <= mst_state_next;
            req_tgl_reg <= req_tgl_next;
            hs_cmd_reg <= hs_cmd_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            ack_sync_reg <= ack_sync_next;
            ack_seen_reg <= ack_seen_next;
            div_reg <= div_next;
        end
    end

    // slave side, advancing only on the downstream enable
    always_comb begin
        slv_state_next = slv_state_reg;
        cmd_next = cmd_reg;
        first_next = first_reg;
        ack_tgl_next = ack_tgl_reg;
        hs_rdata_next = hs_rdata_reg;
        req_seen_next = req_seen_reg;
        req_sync_next = {req_sync_reg[SYNC_LEN-2:0], req_tgl_reg};
        cmd_pop = 1'b0;
        rsp_push = 1'b0;
        if (slv_en) begin
            unique case (slv_state_reg)
                S_IDLE: begin
                    if (fifo_on && !cmd_empty && !rsp_full) begin
                        cmd_pop = 1'b1;
                        cmd_next = cmd_head;
                        first_next = 1'b1;
                        slv_state_next = S_ISSUE;
                    end else if (!fifo_on
                            && toggled(req_sync_reg[SYNC_LEN-1], req_seen_reg)) begin
                        req_seen_next = !req_seen_reg;
                        cmd_next = hs_cmd_reg;
                        first_next = 1'b1;
                        slv_state_next = S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    first_next = 1'b0;
                    if (!s_stall) begin
                        if (cmd_reg[CMD_W-1]) begin
                            ack_tgl_next = fifo_on ? ack_tgl_reg : !ack_tgl_reg;
                            slv_state_next = S_IDLE;
                        end else begin
                            slv_state_next = S_RDWAIT;
                        end
                    end
                end
                S_RDWAIT: begin
                    if (s_rvalid) begin
                        rsp_push = fifo_on;
                        if (!fifo_on) begin
                            hs_rdata_next = s_rdata;
                            ack_tgl_next = !ack_tgl_reg;
                        end
                        slv_state_next = S_IDLE;
                    end
                end
                default: slv_state_next = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slv_state_reg <= S_IDLE;
            cmd_reg <= '0;
            first_reg <= 1'b0;
            ack_tgl_reg <= 1'b0;
            hs_rdata_reg <= '0;
            req_sync_reg <= '0;
            req_seen_reg <= 1'b0;
        end else begin
            slv_state_reg <= slv_state_next;
            cmd_reg <= cmd_next;
            first_reg <= first_next;
            ack_tgl_reg <= ack_tgl_next;
            hs_rdata_reg <= hs_rdata_next;
            req_sync_reg <= req_sync_next;
            req_seen_reg <= req_seen_next;
        end
    end

    assign m_wait = wait_reg;
    assign m_rdata = rdata_reg;
    assign m_rvalid = rvalid_reg;
    assign s_read = (slv_state_reg == S_ISSUE) && !cmd_reg[CMD_W-1];
    assign s_write = (slv_state_reg == S_ISSUE) && cmd_reg[CMD_W-1];
    assign s_addr = cmd_reg[CMD_W-2:DATA_W];
    assign s_wdata = cmd_reg[DATA_W-1:0];
    assign s_first = first_reg;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence ack_arrives;
        (mst_state_reg == M_WAIT_ACK) && toggled(ack_sync_reg[SYNC_LEN-1], ack_seen_reg);
    endsequence
    sequence release_pulse;
        !m_wait ##1 m_wait;
    endsequence

    a_wait_on_capture: assert property (
        (mst_state_reg == M_IDLE) && !fifo_on && m_req |=> m_wait [*2]
    ) else $error("master not held after capture");
    a_release_after_ack: assert property (
        ack_arrives |=> release_pulse
    ) else $error("master not released once after ack");
    a_one_outstanding: assert property (
        (mst_state_reg == M_WAIT_ACK)
            && !toggled(ack_sync_reg[SYNC_LEN-1], ack_seen_reg) |=> m_wait
    ) else $error("master released before ack");
    a_first_on_start: assert property (
        $rose(s_read || s_write) |-> s_first
    ) else $error("first flag missing at transfer start");
    a_first_drops: assert property (
        s_first && slv_en |=> !s_first
    ) else $error("first flag held past first cycle");
    a_stall_holds: assert property (
        (s_read || s_write) && s_stall && slv_en |=> $stable(cmd_reg) && (s_read || s_write)
    ) else $error("stalled transfer dropped");
    a_queue_no_overflow: assert property (
        cmd_full |-> !cmd_push && m_wait
    ) else $error("push into full command queue");
    a_bridge_idle: assert property (
        $rose(s_read || s_write) |-> $past(cmd_pop) || $past(req_seen_reg) != req_seen_reg
    ) else $error("downstream transfer without upstream access");
    a_hs_rvalid_release: assert property (
        m_rvalid && !fifo_on |-> !m_wait && $past(mst_state_reg) == M_WAIT_ACK
    ) else $error("read data returned outside release");
endmodule

// file: shared/crossing_pkg.sv
// constants, types and helpers shared by the memory-mapped crossing adapter
// assumes one reference clock; the far-side rate is an enable pulse from a divider
package crossing_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int CMD_W = 1 + ADDR_W + DATA_W;
    localparam int SYNC_LEN = 2;
    localparam int CMD_DEPTH = 4;
    localparam int RSP_DEPTH = 4;
    localparam int CNT_W = 3;
    localparam int DIV_W = 2;
    localparam logic [DIV_W-1:0] SLV_DIV_LAST = 2'h2;
    localparam logic WAIT_RST = 1'b1;

    typedef enum logic [1:0] {
        XING_HANDSHAKE = 2'h0,
        XING_FIFO = 2'h1,
        XING_AUTO = 2'h2
    } xing_mode_t;

    function automatic logic is_fifo_mode(input xing_mode_t mode, input logic bursts);
        is_fifo_mode = (mode == XING_FIFO) || ((mode == XING_AUTO) && bursts);
    endfunction

    function automatic logic toggled(input logic synced, input logic seen);
        toggled = synced ^ seen;
    endfunction
endpackage

// file: rtl/crossing_fifo.sv
// small synchronous queue used for the command and response paths
// assumes push and pop come from logic on the same clock
`timescale 1ns/100ps
module crossing_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4,
    parameter int CW = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic push,
    input wire logic [W-1:0] wdata,
    // drain side
    input wire logic pop,
    output logic [W-1:0] rdata,
    // level
    output logic [CW-1:0] count,
    output logic full,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] count_reg, count_next;
    logic do_push, do_pop;

    // never overwrites a queued entry nor reads an empty queue
    always_comb begin
        do_push = push && (count_reg != CW'(DEPTH));
        do_pop = pop && (count_reg != '0);
        wr_ptr_next = do_push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = do_pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        count_next = CW'(count_reg + CW'(do_push) - CW'(do_pop));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= wdata;
        end
    end

    assign rdata = mem[rd_ptr_reg];
    assign count = count_reg;
    assign full = (count_reg == CW'(DEPTH));
    assign empty = (count_reg == '0);
endmodule

// file: verification/slave_model.sv
// slave peripheral model: small word memory, stall held high while unselected when wait_slots is nonzero
// assumes the shared ref_clk and acts only on cycles where slv_en is high
`timescale 1ns/100ps
module slave_model
    import crossing_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // slots to stall each transfer
    input wire logic [3:0] wait_slots,
    // slave port
    input wire logic slv_en,
    input wire logic s_read,
    input wire logic s_write,
    input wire logic [ADDR_W-1:0] s_addr,
    input wire logic [DATA_W-1:0] s_wdata,
    input wire logic s_first,
    output logic s_stall,
    output logic [DATA_W-1:0] s_rdata,
    output logic s_rvalid
);
    logic [DATA_W-1:0] mem [16];
    logic [3:0] cnt;
    logic stall_reg;

    // a stall raised one slot late is widened by the first-slot flag
    assign s_stall = stall_reg || s_first;

    always @(posedge ref_clk) begin
        if (rst) begin
            stall_reg <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
            cnt <= 4'h0;
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 32'h0;
            end
        end else if (slv_en) begin
            // read data that is not valid shows a pattern that changes every slot
            s_rvalid <= 1'b0;
            s_rdata <= ~s_rdata;
            if ((s_read || s_write) && s_stall) begin
                cnt <= cnt + 4'h1;
                if (cnt >= wait_slots) begin
                    stall_reg <= 1'b0;
                end
            end else if (s_read || s_write) begin
                // with slots to wait the stall is up before the next selection,
                // otherwise only the first-slot flag stalls the first slot
                stall_reg <= (wait_slots != 4'h0);
                cnt <= 4'h0;
                if (s_write) begin
                    mem[s_addr[3:0]] <= s_wdata;
                end else begin
                    s_rvalid <= 1'b1;
                    s_rdata <= mem[s_addr[3:0]];
                end
            end
        end
    end
endmodule

// file: verification/tb_top.sv
// self-checking bench for the crossing adapter against a queue-based reference
// assumes slave_model on the downstream port and the shared crossing package
`timescale 1ns/100ps
module tb_top;
    import crossing_pkg::*;
    logic ref_clk;
    logic rst;
    xing_mode_t xing_mode;
    logic link_bursts;
    logic m_read;
    logic m_write;
    logic [ADDR_W-1:0] m_addr;
    logic [DATA_W-1:0] m_wdata;
    logic m_wait;
    logic [DATA_W-1:0] m_rdata;
    logic m_rvalid;
    logic slv_en;
    logic s_read;
    logic s_write;
    logic [ADDR_W-1:0] s_addr;
    logic [DATA_W-1:0] s_wdata;
    logic s_first;
    logic s_stall;
    logic [DATA_W-1:0] s_rdata;
    logic s_rvalid;
    logic [3:0] wait_slots;
    int fails;
    int cmp_count;
    int seed;
    int lows;
    int taken;
    int ds_done;
    int base;
    logic idle_chk;
    logic saw_full;
    logic fifo_on;
    logic in_xfer;
    logic [ADDR_W-1:0] a0;
    logic [DATA_W-1:0] ref_mem [16];
    logic [DATA_W-1:0] rd_q [$];
    logic [CMD_W-1:0] ds_q [$];

    mm_clock_crossing_adapter mm_clock_crossing_adapter_i (
        .ref_clk(ref_clk), .rst(rst), .xing_mode(xing_mode), .link_bursts(link_bursts),
        .m_read(m_read), .m_write(m_write), .m_addr(m_addr), .m_wdata(m_wdata),
        .m_wait(m_wait), .m_rdata(m_rdata), .m_rvalid(m_rvalid), .slv_en(slv_en),
        .s_read(s_read), .s_write(s_write), .s_addr(s_addr), .s_wdata(s_wdata),
        .s_first(s_first), .s_stall(s_stall), .s_rdata(s_rdata), .s_rvalid(s_rvalid)
    );
    slave_model slave_model_i (
        .ref_clk(ref_clk), .rst(rst), .wait_slots(wait_slots), .slv_en(slv_en),
        .s_read(s_read), .s_write(s_write), .s_addr(s_addr), .s_wdata(s_wdata),
        .s_first(s_first), .s_stall(s_stall), .s_rdata(s_rdata), .s_rvalid(s_rvalid)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // expectations are queued when the request is presented, in master order
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(negedge ref_clk);
        m_read = !wr;
        m_write = wr;
        m_addr = a;
        m_wdata = d;
        ds_q.push_back({wr, a, wr ? d : 32'h0});
        if (wr) begin
            ref_mem[a[3:0]] = d;
        end else begin
            rd_q.push_back(ref_mem[a[3:0]]);
        end
        n = 0;
        while (m_wait !== 1'b0 && n < 400) begin
            saw_full = 1'b1;
            @(negedge ref_clk);
            n++;
        end
        if (n == 400) begin
            fails++;
            end_of_test();
        end
        @(posedge ref_clk);
        taken++;
    endtask

    task automatic drain();
        int n;
        @(negedge ref_clk);
        m_read = 1'b0;
        m_write = 1'b0;
        n = 0;
        while ((rd_q.size() != 0 || ds_q.size() != 0) && n < 600) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 600) begin
            fails++;
            end_of_test();
        end
        repeat (6) @(negedge ref_clk);
    endtask

    always @(negedge ref_clk) begin
        if (rst) begin
            in_xfer = 1'b0;
        end else begin
            if (m_rvalid === 1'b1 && rd_q.size() == 0) begin
                check("read pulse count", 64'h0, 64'h1);
            end else if (m_rvalid === 1'b1) begin
                check("read data", rd_q.pop_front(), m_rdata);
            end
            if (m_wait === 1'b0 && !fifo_on) begin
                lows++;
            end
            if (slv_en === 1'b1 && (s_read === 1'b1 || s_write === 1'b1)) begin
                check("first flag", !in_xfer, s_first);
                in_xfer = s_stall;
            end
            if (slv_en === 1'b1 && (s_read || s_write) && s_stall === 1'b0) begin
                ds_done++;
                check("reissued", ds_q.pop_front(), {s_write, s_addr, s_write ? s_wdata : 32'h0});
            end
            if (idle_chk && (s_read !== 1'b0 || s_write !== 1'b0)) begin
                check("idle port", 64'h0, 64'h1);
            end
        end
    end

    initial begin
        seed = 32'hfa5f6a10;
        fails = 0;
        cmp_count = 0;
        ds_done = 0;
        rst = 1'b1;
        xing_mode = XING_HANDSHAKE;
        link_bursts = 1'b0;
        m_read = 1'b0;
        m_write = 1'b0;
        m_addr = 16'h0;
        m_wdata = 32'h0;
        wait_slots = 4'h0;
        idle_chk = 1'b0;
        fifo_on = 1'b0;
        // handshake, fifo, auto with bursts, auto without bursts
        for (int k = 0; k < 4; k++) begin
            @(negedge ref_clk);
            rst = 1'b1;
            xing_mode = xing_mode_t'(k < 3 ? k : 2);
            link_bursts = (k == 2);
            fifo_on = (xing_mode == XING_FIFO) || (xing_mode == XING_AUTO && link_bursts);
            for (int i = 0; i < 16; i++) begin
                ref_mem[i] = 32'h0;
            end
            repeat (6) @(negedge ref_clk);
            rst = 1'b0;
            lows = 0;
            taken = 0;
            repeat (4) @(negedge ref_clk);
            check("idle stall", !fifo_on, m_wait);
            for (int t = 0; t < 10; t++) begin
                wait_slots <= 4'($unsigned($random(seed)) % 3);
                xfer(1'($random(seed)), 16'($random(seed)), $random(seed));
            end
            // queued random transfers must not be counted by the burst below
            drain();
            wait_slots <= 4'h4;
            a0 = 16'($random(seed));
            saw_full = 1'b0;
            base = ds_done;
            for (int t = 0; t < 6; t++) begin
                xfer(1'b1, a0 + 16'(t), $random(seed));
                if (t == 3) begin
                    check("outstanding", fifo_on, (ds_done - base) < 3);
                end
            end
            check("full stall", 1'b1, saw_full);
            for (int t = 0; t < 6; t++) begin
                xfer(1'b0, a0 + 16'(t), 32'h0);
            end
            drain();
            if (!fifo_on) begin
                check("release cycles", taken, lows);
            end
            idle_chk = 1'b1;
            repeat (40) @(negedge ref_clk);
            idle_chk = 1'b0;
        end
        end_of_test();
    end
endmodule
